// [logic/fe_rx_pkg.sv]
// constants for the 100 Mb/s receive line decoder and pcs
package fe_rx_pkg;

  // timing, in the units printed, and derived cycle counts at sys_clk
  localparam int CLK_PERIOD_NS = 10;
  localparam int SD_QUAL_NS    = 1000;
  localparam int SD_QUAL_CYC   = (SD_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LINK_UP_US    = 395;
  localparam int LINK_UP_CYC   = (LINK_UP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_US       = 722;
  localparam int HOLD_CYC      = (HOLD_US * 1000) / CLK_PERIOD_NS;

  // code-group geometry and sync thresholds
  localparam int CG_BITS          = 5;
  localparam int LOCK_IDLE_GROUPS = 12;
  localparam int LOCK_ONES        = LOCK_IDLE_GROUPS * CG_BITS;
  localparam int HOLD_IDLE_BITS   = 58;
  localparam int END_IDLE_GROUPS  = 2;
  localparam int FCE_W            = 16;

  // scrambler polynomial x^11 + x^9 + 1
  localparam int SCR_W = 11;
  localparam int TAP_A = 10;
  localparam int TAP_B = 8;

  // code-groups and nibbles
  localparam logic [4:0] CG_IDLE      = 5'h1f;
  localparam logic [4:0] CG_J         = 5'h18;
  localparam logic [4:0] CG_K         = 5'h11;
  localparam logic [4:0] CG_T         = 5'h0d;
  localparam logic [4:0] CG_R         = 5'h07;
  localparam logic [9:0] JK_PAIR      = {CG_J, CG_K};
  localparam logic [9:0] SR_ALL_ONES  = 10'h3ff;
  localparam int         SSD_ZERO_POS = 7;
  localparam logic [3:0] NIB_PREAMBLE = 4'h5;
  localparam logic [3:0] NIB_BAD_SSD  = 4'he;
  localparam logic [1:0] LVL_RESET    = 2'h0;

  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_BAD} pcs_state_e;

endpackage : fe_rx_pkg

// [logic/fe_rx_pcs_decoder.sv]
// 100 Mb/s receive back end: line decode, descrambler, aligner, 5b/4b decode, link monitor
// Contract
// - link pulses alone never raise signal detect
// - three-level symbols become a binary nrzi stream first
// - nrzi becomes nrz: transition is one, none is zero
// - received bits are grouped into 5-bit symbols for the pcs
// - descrambler keystream matches far scrambler; data is scrambled bit xor keystream
// - lock only after 12 consecutive unscrambled idle groups
// - hold timer of 722 us restarts on 58 bit times of idle
// - hold timer expiry drops lock and fully resets the descrambler
// - symbol boundary fixed when J/K pair 11000 10001 is seen
// - aligner reads descrambler output, or nrz directly when bypassed
// - groups decode by table; J/K after idles gives nibbles 0101 0101
// - decoding ends on T/R or on two idle groups
// - link up only after signal detect held 395 us
// - idle to non-idle without J/K is a bad start of stream
// - bad start drives rx_er and rxd 1110 each group until two idles
// - each bad start adds exactly one to the false carrier counter
// - after bad start, two idles drop rx_er and crs
// - control groups inside data are invalid and raise rx_er
// - end of stream is 01101 then 00111
`timescale 1ns/1ns
`default_nettype none

module fe_rx_pcs_decoder #(
  parameter int SD_CYC   = fe_rx_pkg::SD_QUAL_CYC,
  parameter int LINK_CYC = fe_rx_pkg::LINK_UP_CYC,
  parameter int HOLD_CYC = fe_rx_pkg::HOLD_CYC
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic                        sig_energy,
  input  wire logic                        sym_valid,
  input  wire logic [1:0]                  sym_level,
  input  wire logic                        descr_bypass,
  output logic                             link_up,
  output logic                             descr_locked,
  output logic [3:0]                       rxd,
  output logic                             rx_dv,
  output logic                             rx_er,
  output logic                             crs,
  output logic                             rx_nib_stb,
  output logic [fe_rx_pkg::FCE_W-1:0]      false_carrier_event_counter
);
  import fe_rx_pkg::*;
  localparam int SD_W   = $clog2(SD_CYC + 1);
  localparam int LINK_W = $clog2(LINK_CYC + 1);
  localparam int HOLD_W = $clog2(HOLD_CYC + 1);
  // data code-groups packed by nibble value, nibble 0 in the low five bits
  localparam logic [79:0] DATA_CG = {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12,
                                     5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};

  // 5b to {valid, nibble}; control and violation codes miss the table, so come back invalid
  function automatic logic [4:0] decode_cg(input logic [4:0] cg);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (cg == DATA_CG[5*i +: 5]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : decode_cg

  ////////////////////////////////////////////////////////////////////////////
  // signal detect qualification and link monitor
  logic [SD_W-1:0]   sd_cnt_r, sd_cnt_nxt;
  logic [LINK_W-1:0] link_cnt_r, link_cnt_nxt;
  logic              link_up_r, link_up_nxt;
  logic              sig_det;
  // a link pulse is ~100 ns, far shorter than the qualification window
  assign sig_det = (sd_cnt_r == SD_W'(SD_CYC));
  always_comb begin
    sd_cnt_nxt   = sd_cnt_r;
    link_cnt_nxt = link_cnt_r;
    link_up_nxt  = link_up_r;
    if (!sig_energy) begin
      sd_cnt_nxt = '0;
    end else if (!sig_det) begin
      sd_cnt_nxt = sd_cnt_r + SD_W'(1);
    end
    if (!sig_det) begin
      link_cnt_nxt = '0;
      link_up_nxt  = 1'b0;
    end else if (link_cnt_r == LINK_W'(LINK_CYC - 1)) begin
      link_up_nxt = 1'b1;
    end else begin
      link_cnt_nxt = link_cnt_r + LINK_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sd_cnt_r   <= '0;
      link_cnt_r <= '0;
      link_up_r  <= 1'b0;
    end else begin
      sd_cnt_r   <= sd_cnt_nxt;
      link_cnt_r <= link_cnt_nxt;
      link_up_r  <= link_up_nxt;
    end
  end
  assign link_up = link_up_r;

  ////////////////////////////////////////////////////////////////////////////
  // mlt-3 to nrzi to nrz
  logic [1:0] lvl_r, lvl_nxt;
  logic       nrzi_r, nrzi_nxt;
  logic       nrz_bit;

  always_comb begin
    lvl_nxt  = lvl_r;
    nrzi_nxt = nrzi_r;
    if (sym_valid) begin
      lvl_nxt  = sym_level;
      nrzi_nxt = nrzi_r ^ (sym_level != lvl_r);
    end
  end
  assign nrz_bit = nrzi_nxt ^ nrzi_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lvl_r  <= LVL_RESET;
      nrzi_r <= 1'b0;
    end else begin
      lvl_r  <= lvl_nxt;
      nrzi_r <= nrzi_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // descrambler, lock search and hold timer
  logic [SCR_W-1:0]  lfsr_r, lfsr_nxt;
  logic              lock_r, lock_nxt;
  logic [6:0]        run_r, run_nxt;
  logic [HOLD_W-1:0] hold_r, hold_nxt;
  logic              key_bit;
  logic              ud_bit;
  logic              align_bit;
  assign key_bit   = lfsr_r[TAP_A] ^ lfsr_r[TAP_B];
  assign ud_bit    = nrz_bit ^ key_bit;
  assign align_bit = descr_bypass ? nrz_bit : ud_bit;
  // while searching, the lfsr is fed the keystream implied by idle (sd = ~n)
  always_comb begin
    lfsr_nxt = lfsr_r;
    lock_nxt = lock_r;
    run_nxt  = run_r;
    hold_nxt = hold_r;
    // link loss, or too little idle before expiry: start over from a clean register
    if (!link_up_r || (lock_r && hold_r == HOLD_W'(HOLD_CYC - 1))) begin
      lfsr_nxt = '0;
      lock_nxt = 1'b0;
      run_nxt  = '0;
      hold_nxt = '0;
    end else if (!lock_r) begin
      if (sym_valid) begin
        lfsr_nxt = {lfsr_r[SCR_W-2:0], ~nrz_bit};
        if (key_bit == ~nrz_bit) begin
          run_nxt = run_r + 7'h01;
          if (run_r == 7'(LOCK_ONES - 1)) begin
            lock_nxt = 1'b1;
            run_nxt  = '0;
            hold_nxt = '0;
          end
        end else begin
          run_nxt = '0;
        end
      end
    end else begin
      hold_nxt = hold_r + HOLD_W'(1);
      if (sym_valid) begin
        lfsr_nxt = {lfsr_r[SCR_W-2:0], key_bit};
        run_nxt  = ud_bit ? run_r + 7'h01 : 7'h00;
        if (ud_bit && run_r == 7'(HOLD_IDLE_BITS - 1)) begin
          hold_nxt = '0;
          run_nxt  = '0;
        end
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lfsr_r <= '0;
      lock_r <= 1'b0;
      run_r  <= '0;
      hold_r <= '0;
    end else begin
      lfsr_r <= lfsr_nxt;
      lock_r <= lock_nxt;
      run_r  <= run_nxt;
      hold_r <= hold_nxt;
    end
  end
  assign descr_locked = lock_r;

  ////////////////////////////////////////////////////////////////////////////
  // alignment, 5b/4b decode, bad start detection and mii outputs
  pcs_state_e       st_r, st_nxt;
  logic [9:0]       sr_r, sr_nxt;
  logic [2:0]       bit_r, bit_nxt;
  logic [4:0]       pend_r, pend_nxt;
  logic             pre_r, pre_nxt;
  logic [1:0]       idl_r, idl_nxt;
  logic [3:0]       rxd_r, rxd_nxt;
  logic             dv_r, dv_nxt;
  logic             er_r, er_nxt;
  logic             stb_r, stb_nxt;
  logic [FCE_W-1:0] fce_r, fce_nxt;
  logic             active;
  logic             grp_done;
  logic [4:0]       cg;
  logic [4:0]       pend_dec;
  assign active   = link_up_r && (lock_r || descr_bypass);
  // newest group built from the register, so cg reads no value the decode process writes
  assign cg       = {sr_r[3:0], align_bit};
  assign grp_done = sym_valid && (bit_r == 3'(CG_BITS - 1));
  assign pend_dec = decode_cg(pend_r);
  // output nibbles lag one group so the J slot can still carry preamble
  always_comb begin
    st_nxt   = st_r;
    sr_nxt   = sr_r;
    bit_nxt  = bit_r;
    pend_nxt = pend_r;
    pre_nxt  = pre_r;
    idl_nxt  = idl_r;
    rxd_nxt  = rxd_r;
    dv_nxt   = dv_r;
    er_nxt   = er_r;
    stb_nxt  = 1'b0;
    fce_nxt  = fce_r;
    if (!active) begin
      st_nxt  = ST_IDLE;
      sr_nxt  = SR_ALL_ONES;
      rxd_nxt = '0;
      dv_nxt  = 1'b0;
      er_nxt  = 1'b0;
    end else if (sym_valid) begin
      sr_nxt  = {sr_r[8:0], align_bit};
      bit_nxt = (bit_r == 3'(CG_BITS - 1)) ? 3'h0 : bit_r + 3'h1;
      case (st_r)
        ST_IDLE: begin
          // first zero after idle has reached the J position of the window
          if (!sr_nxt[SSD_ZERO_POS]) begin
            bit_nxt = '0;
            stb_nxt = 1'b1;
            idl_nxt = '0;
            if (sr_nxt == JK_PAIR) begin
              st_nxt  = ST_DATA;
              rxd_nxt = NIB_PREAMBLE;
              dv_nxt  = 1'b1;
              er_nxt  = 1'b0;
              pre_nxt = 1'b1;
            end else begin
              st_nxt  = ST_BAD;
              rxd_nxt = NIB_BAD_SSD;
              dv_nxt  = 1'b0;
              er_nxt  = 1'b1;
              fce_nxt = fce_r + FCE_W'(1);
            end
          end
        end
        ST_DATA: begin
          if (grp_done) begin
            stb_nxt = 1'b1;
            if ((cg == CG_IDLE && idl_r != 2'h0) ||
                (cg == CG_R && pend_r == CG_T && !pre_r)) begin
              st_nxt  = ST_IDLE;
              sr_nxt  = SR_ALL_ONES;
              rxd_nxt = '0;
              dv_nxt  = 1'b0;
              er_nxt  = 1'b0;
            end else begin
              rxd_nxt  = pre_r ? NIB_PREAMBLE : pend_dec[3:0];
              er_nxt   = !pre_r && !pend_dec[4];
              dv_nxt   = 1'b1;
              pend_nxt = cg;
              pre_nxt  = 1'b0;
              idl_nxt  = (cg == CG_IDLE) ? 2'h1 : 2'h0;
            end
          end
        end
        ST_BAD: begin
          if (grp_done) begin
            stb_nxt = 1'b1;
            idl_nxt = (cg == CG_IDLE) ? idl_r + 2'h1 : 2'h0;
            if (cg == CG_IDLE && idl_r == 2'(END_IDLE_GROUPS - 1)) begin
              st_nxt  = ST_IDLE;
              sr_nxt  = SR_ALL_ONES;
              rxd_nxt = '0;
              er_nxt  = 1'b0;
            end else begin
              rxd_nxt = NIB_BAD_SSD;
              er_nxt  = 1'b1;
            end
          end
        end
        default: st_nxt = ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r   <= ST_IDLE;
      sr_r   <= SR_ALL_ONES;
      bit_r  <= '0;
      pend_r <= CG_IDLE;
      pre_r  <= 1'b0;
      idl_r  <= '0;
      rxd_r  <= '0;
      dv_r   <= 1'b0;
      er_r   <= 1'b0;
      stb_r  <= 1'b0;
      fce_r  <= '0;
    end else begin
      st_r   <= st_nxt;
      sr_r   <= sr_nxt;
      bit_r  <= bit_nxt;
      pend_r <= pend_nxt;
      pre_r  <= pre_nxt;
      idl_r  <= idl_nxt;
      rxd_r  <= rxd_nxt;
      dv_r   <= dv_nxt;
      er_r   <= er_nxt;
      stb_r  <= stb_nxt;
      fce_r  <= fce_nxt;
    end
  end
  // carrier follows the state: good or bad start until idle returns
  assign crs                         = (st_r != ST_IDLE);
  assign rxd                         = rxd_r;
  assign rx_dv                       = dv_r;
  assign rx_er                       = er_r;
  assign rx_nib_stb                  = stb_r;
  assign false_carrier_event_counter = fce_r;
endmodule : fe_rx_pcs_decoder
`default_nettype wire

// [verification/fe_rx_checker.sv]
// port-level checks of the receive pcs, bound into the decoder
`timescale 1ns/1ns
`default_nettype none
module fe_rx_checker #(
  parameter int SD_CYC   = 10,
  parameter int LINK_CYC = 50
) (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       sig_energy,
  input wire logic       link_up,
  input wire logic       descr_locked,
  input wire logic [3:0] rxd,
  input wire logic       rx_dv,
  input wire logic       rx_er,
  input wire logic       crs,
  input wire logic       rx_nib_stb,
  input wire logic [fe_rx_pkg::FCE_W-1:0] false_carrier_event_counter
);
  import fe_rx_pkg::*;
  int unsigned           en_cnt_r;
  wire [FCE_W-1:0]       fcc = false_carrier_event_counter;
  ////////////////////////////////////////
  // run length of line energy; a link pulse restarts it, which is the point
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !sig_energy) en_cnt_r <= 0;
    else en_cnt_r <= en_cnt_r + 1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  a_link_qualified: assert property ($rose(link_up) |->
    en_cnt_r inside {[SD_CYC + LINK_CYC - 3 : SD_CYC + LINK_CYC + 3]}) else $error("early link");
  a_link_drop: assert property (!sig_energy [*4] |-> !link_up)
    else $error("link kept without energy");
  a_lock_on_link: assert property ($rose(descr_locked) |-> link_up)
    else $error("lock without link");
  a_lock_drops: assert property (!link_up [*2] |-> !descr_locked)
    else $error("lock kept after link loss");
  a_bad_nibble: assert property (rx_nib_stb && rx_er && !rx_dv |->
    rxd == NIB_BAD_SSD && crs) else $error("bad start nibble wrong");
  a_fce_step: assert property ($changed(fcc) |-> rx_nib_stb && rx_er && !rx_dv &&
    fcc == FCE_W'($past(fcc) + 1)) else $error("false carrier count step");
  a_dv_in_crs: assert property (rx_dv |-> crs)
    else $error("data valid outside carrier");
  a_clean_end: assert property ($fell(crs) |-> !rx_er && !rx_dv)
    else $error("carrier end with error or valid");
  a_stb_cadence: assert property (rx_nib_stb && crs |=>
    !rx_nib_stb [*3] ##[1:3] (rx_nib_stb || !crs)) else $error("nibble strobe cadence");
  a_nibble_holds: assert property (!rx_nib_stb && crs && $past(crs) |->
    $stable(rxd) && $stable(rx_dv) && $stable(rx_er)) else $error("nibble moved off strobe");
  // main scenarios seen at least once
  c_preamble: cover property (rx_nib_stb && rx_dv && rxd == NIB_PREAMBLE);
  c_bad_start: cover property (rx_nib_stb && rx_er && !rx_dv);
  c_lock_lost: cover property ($fell(descr_locked));
endmodule : fe_rx_checker
bind fe_rx_pcs_decoder fe_rx_checker #(.SD_CYC(SD_CYC), .LINK_CYC(LINK_CYC))
  u_fe_rx_checker (.sys_clk(sys_clk), .rst_n(rst_n), .sig_energy(sig_energy),
  .link_up(link_up), .descr_locked(descr_locked), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
  .crs(crs), .rx_nib_stb(rx_nib_stb),
  .false_carrier_event_counter(false_carrier_event_counter));
`default_nettype wire

// [verification/mii_mac_model.sv]
// mac-side capture of mii receive nibbles, one entry per strobe
`timescale 1ns/1ns
`default_nettype none
module mii_mac_model (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [3:0] rxd,
  input wire logic       rx_dv,
  input wire logic       rx_er,
  input wire logic       rx_nib_stb
);
  // {dv, er, nibble}; the bench empties it per transfer, so no depth limit
  logic [5:0] got[$];
  // a mac looks only at the strobe, values between strobes are not data
  always @(posedge sys_clk) begin
    if (rst_n === 1'b1 && rx_nib_stb === 1'b1) got.push_back({rx_dv, rx_er, rxd});
  end
endmodule : mii_mac_model
`default_nettype wire

// [verification/tb_top.sv]
// bench for the receive pcs: line driver, mac capture, bounded checks
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import fe_rx_pkg::*;
  localparam int SDC = 10;
  localparam int LKC = 50;
  logic             sys_clk;
  logic             rst_n;
  logic             sig_energy;
  logic             sym_valid;
  logic [1:0]       sym_level;
  logic             descr_bypass;
  logic             link_up;
  logic             descr_locked;
  logic [3:0]       rxd;
  logic             rx_dv;
  logic             rx_er;
  logic             crs;
  logic             rx_nib_stb;
  logic [FCE_W-1:0] fce;
  logic [FCE_W-1:0] fce_exp;
  logic [15:0]      rnd;
  logic [10:0]      scr;
  logic [1:0]       mlt;
  int               n;
  int               mismatches;
  int               tests_run;
  // data code-groups in nibble order
  logic [4:0]       enc_t [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                   5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  fe_rx_pcs_decoder #(.SD_CYC(SDC), .LINK_CYC(LKC), .HOLD_CYC(2000)) u_fe_rx_pcs_decoder (
    .sys_clk(sys_clk), .rst_n(rst_n), .sig_energy(sig_energy), .sym_valid(sym_valid),
    .sym_level(sym_level), .descr_bypass(descr_bypass), .link_up(link_up),
    .descr_locked(descr_locked), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs),
    .rx_nib_stb(rx_nib_stb), .false_carrier_event_counter(fce));
  mii_mac_model u_mii_mac_model (.sys_clk(sys_clk), .rst_n(rst_n), .rxd(rxd),
    .rx_dv(rx_dv), .rx_er(rx_er), .rx_nib_stb(rx_nib_stb));
  // 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  function automatic logic [15:0] lfsr16(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr16
  // a data nibble as the mac must see it: valid, no error
  function automatic logic [5:0] mii(input logic [3:0] d);
    return {2'b10, d};
  endfunction : mii
  task automatic results();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : chk
  // scramble unless bypassed, then a one steps the three-level line, a zero holds it
  task automatic tx_bit(input logic b);
    logic sd;
    sd = descr_bypass ? b : b ^ scr[10] ^ scr[8];
    scr = {scr[9:0], scr[10] ^ scr[8]};
    if (sd) mlt = mlt + 2'h1;
    @(posedge sys_clk);
    sym_valid <= 1'b1;
    sym_level <= {mlt == 2'h3, mlt[0]};
  endtask : tx_bit
  task automatic tx_grp(input logic [4:0] g);
    for (int i = 4; i >= 0; i--) tx_bit(g[i]);
  endtask : tx_grp
  // idles, then the line goes quiet so checks never see repeated symbols
  task automatic idles(input int k);
    repeat (k) tx_grp(CG_IDLE);
    @(posedge sys_clk);
    sym_valid <= 1'b0;
    #1;
  endtask : idles
  task automatic get_lock();
    idles(8);
    chk(16'(descr_locked), 16'h0);
    for (int i = 0; i < 40 && descr_locked !== 1'b1; i++) idles(1);
    if (descr_locked !== 1'b1) begin
      mismatches++;
      results();
    end
  endtask : get_lock
  // one frame; output lags one group, so nibble order equals send order
  task automatic pkt(input int k, input logic ctl, input logic tr);
    logic [3:0] d;
    logic [5:0] exp[$];
    u_mii_mac_model.got.delete();
    tx_grp(CG_J);
    tx_grp(CG_K);
    exp = '{6'h25, 6'h25};
    for (int i = 0; i < k; i++) begin
      rnd = lfsr16(rnd);
      d = (k == 16) ? 4'(i) : rnd[3:0];
      if (ctl && i == 2) begin
        tx_grp(CG_J);
        exp.push_back(6'h30);
      end
      tx_grp(enc_t[d]);
      exp.push_back(mii(d));
    end
    if (tr) begin
      tx_grp(CG_T);
      tx_grp(CG_R);
      exp.push_back(6'h00);
    end
    idles(6);
    chk(16'(u_mii_mac_model.got.size() >= exp.size()), 16'h1);
    for (int i = 0; i < exp.size() && i < u_mii_mac_model.got.size(); i++)
      chk(16'(u_mii_mac_model.got[i]), 16'(exp[i]));
    chk(16'({crs, rx_dv, rx_er}), 16'h0);
  endtask : pkt
  // non-idle straight after idles, no delimiter in front
  task automatic bad();
    u_mii_mac_model.got.delete();
    tx_grp(enc_t[2]);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr16(rnd);
      tx_grp(enc_t[rnd[3:0]]);
    end
    idles(6);
    fce_exp = fce_exp + 16'h1;
    chk(16'(u_mii_mac_model.got.size() > 0), 16'h1);
    for (int i = 0; i < u_mii_mac_model.got.size(); i++)
      chk(16'(u_mii_mac_model.got[i] == 6'h1e || (i > 0 && u_mii_mac_model.got[i] == 6'h00)),
          16'h1);
    chk(fce, fce_exp);
    chk(16'({crs, rx_er}), 16'h0);
  endtask : bad
  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    sig_energy = 1'b0;
    sym_valid = 1'b0;
    sym_level = 2'h0;
    descr_bypass = 1'b0;
    mismatches = 0;
    tests_run = 0;
    rnd = 16'hb082;
    scr = 11'h5a5;
    mlt = 2'h0;
    fce_exp = 16'h0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk(16'({link_up, descr_locked, rx_dv, rx_er, crs, rx_nib_stb}), 16'h0);
    chk(fce, 16'h0);
    repeat (4) begin
      @(posedge sys_clk);
      sig_energy <= 1'b1;
      repeat (SDC / 2) @(posedge sys_clk);
      sig_energy <= 1'b0;
      repeat (20) @(posedge sys_clk);
    end
    #1;
    chk(16'(link_up), 16'h0);
    @(posedge sys_clk);
    sig_energy <= 1'b1;
    #1;
    for (n = 0; n < 200 && link_up !== 1'b1; n++) @(posedge sys_clk) #1;
    if (n == 200) begin
      mismatches++;
      results();
    end
    chk(16'(n >= SDC + LKC - 2 && n <= SDC + LKC + 3), 16'h1);
    get_lock();
    pkt(16, 1'b0, 1'b1);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr16(rnd);
      pkt(4 + int'(rnd[2:0]), k == 1, k != 2);
    end
    bad();
    idles(500);
    chk(16'(descr_locked), 16'h1);
    tx_grp(CG_J);
    tx_grp(CG_K);
    for (int i = 0; i < 440; i++) begin
      rnd = lfsr16(rnd);
      tx_grp(enc_t[rnd[3:0]]);
    end
    idles(1);
    chk(16'({descr_locked, crs}), 16'h0);
    get_lock();
    pkt(8, 1'b0, 1'b1);
    @(posedge sys_clk);
    descr_bypass <= 1'b1;
    #1;
    idles(4);
    pkt(8, 1'b0, 1'b1);
    // energy gone: link falls, then lock and carrier with it
    @(posedge sys_clk);
    sig_energy <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(16'({link_up, descr_locked, crs}), 16'h0);
    results();
  end
endmodule : tb_top
`default_nettype wire
